// ==== rtl/mrx_regs.svh ====
// Register offsets, field positions and reset values of the receive mode, data and status bank.
// Assumes an 8-bit address phase on the serial control bus, sent most significant bit first.
`ifndef MRX_REGS_SVH
`define MRX_REGS_SVH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define MRX_ADDR_GEN_RESET     8'h01
`define MRX_ADDR_RX_MODE       8'hE2
`define MRX_ADDR_TX_BYTE       8'hE3
`define MRX_ADDR_TX_BYTE_OVSP  8'hE4
`define MRX_ADDR_RX_BYTE       8'hE5
`define MRX_ADDR_EVENT_FLAGS   8'hE6

// ----------------------------------------------------------------
// Receive mode fields
// ----------------------------------------------------------------
`define MRX_RXM_MODE_HI        15
`define MRX_RXM_MODE_LO        12
`define MRX_RXM_GAIN_HI        11
`define MRX_RXM_GAIN_LO        9
`define MRX_RXM_EQ_BIT         8
`define MRX_RXM_DESC_HI        7
`define MRX_RXM_DESC_LO        6
`define MRX_RXM_USART_HI       5
`define MRX_RXM_USART_LO       3
`define MRX_RXM_FMT_HI         2
`define MRX_RXM_FMT_LO         0
`define MRX_RXM_RESET          16'h0000
`define MRX_MODE_TONES         4'h1
`define MRX_MODE_OFF           4'h0
`define MRX_USART_SYNC         3'h7
`define MRX_USART_SS_PLAIN     3'h6
`define MRX_USART_SS_OV8       3'h5
`define MRX_USART_SS_OV4       3'h4

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define MRX_ST_IRQ             15
`define MRX_ST_RING            14
`define MRX_ST_PROG            13
`define MRX_ST_RX_READY        6
`define MRX_ST_RX_OVFL         5
`define MRX_ST_FRAMING         4
`define MRX_ST_PARITY          3
`define MRX_ST_RESET           16'h0000
`define MRX_ST_CLR_MASK        16'h3FFF

// ----------------------------------------------------------------
// Lengths and counts
// ----------------------------------------------------------------
`define MRX_LEN_ADDR           5'd8
`define MRX_LEN_BYTE           5'd8
`define MRX_LEN_WORD           5'd16
`define MRX_OV8_WINDOW         4'd8
`define MRX_OV4_WINDOW         4'd4

`endif

// ==== rtl/mrx_pkg.sv ====
// Types shared by the receive mode, data and status bank.
// Assumes the constants of mrx_regs.svh are included where numbers are needed.
package mrx_pkg;

  // ----------------------------------------------------------------
  // Serial bus phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SER_ADDR, SER_WRITE, SER_READ, SER_IGNORE} mrx_ser_e;

  // ----------------------------------------------------------------
  // Receive character engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CH_IDLE, CH_DATA, CH_PARITY, CH_STOP, CH_SYNC} mrx_char_e;

endpackage : mrx_pkg

// ==== rtl/mrx_rx_char.sv ====
// Receive character engine: turns demodulated bits into bytes.
// Assumes one bit per rx_bit_valid pulse on ref_clk from the demodulator.
`include "mrx_regs.svh"

module mrx_rx_char
(
  input  wire logic       ref_clk,
  input  wire logic       clr,
  input  wire logic       rx_bit_valid,
  input  wire logic       rx_bit,
  input  wire logic       enable,
  input  wire logic [2:0] usart_mode,
  input  wire logic [2:0] char_format,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            framing_err,
  output logic            parity_even
);
  import mrx_pkg::*;

  mrx_char_e  state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       par_reg;
  logic [3:0] char_cnt_reg;
  logic       miss_used_reg;
  logic [3:0] data_len;
  logic [3:0] window;
  logic       sync_mode;

  assign data_len  = 4'd5 + {2'b00, char_format[2:1]};
  assign sync_mode = (usart_mode == `MRX_USART_SYNC);
  assign window    = (usart_mode == `MRX_USART_SS_OV8) ? `MRX_OV8_WINDOW : `MRX_OV4_WINDOW;

  // ----------------------------------------------------------------
  // Character assembly
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    byte_valid  <= 1'b0;
    framing_err <= 1'b0;
    if (clr || !enable)
    begin
      state_reg     <= CH_IDLE;
      bit_cnt_reg   <= 4'd0;
      shift_reg     <= 8'h00;
      par_reg       <= 1'b0;
      char_cnt_reg  <= 4'd0;
      miss_used_reg <= 1'b0;
      byte_data     <= 8'h00;
      parity_even   <= 1'b0;
    end
    else if (rx_bit_valid)
    begin
      case (state_reg)
        CH_IDLE:
        begin
          if (sync_mode)
          begin
            state_reg   <= CH_SYNC;
            shift_reg   <= {rx_bit, 7'h00};
            bit_cnt_reg <= 4'd1;
          end
          else if (!rx_bit)
          begin
            state_reg   <= CH_DATA;
            bit_cnt_reg <= 4'd0;
            par_reg     <= 1'b0;
            shift_reg   <= 8'h00;
          end
        end
        CH_SYNC:
        begin
          shift_reg   <= {rx_bit, shift_reg[7:1]};
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
          if (bit_cnt_reg == 4'd7)
          begin
            byte_data   <= {rx_bit, shift_reg[7:1]};
            byte_valid  <= 1'b1;
            bit_cnt_reg <= 4'd0;
          end
          if (!sync_mode)
          begin
            state_reg <= CH_IDLE;
          end
        end
        CH_DATA:
        begin
          shift_reg   <= {rx_bit, shift_reg[7:1]};
          par_reg     <= par_reg ^ rx_bit;
          bit_cnt_reg <= bit_cnt_reg + 4'd1;
          if (bit_cnt_reg == data_len - 4'd1)
          begin
            state_reg <= char_format[0] ? CH_PARITY : CH_STOP;
          end
        end
        CH_PARITY:
        begin
          par_reg   <= par_reg ^ rx_bit;
          state_reg <= CH_STOP;
        end
        CH_STOP:
        begin
          byte_data    <= ({rx_bit, shift_reg[7:1]} & 8'h00) | (shift_reg >> (4'd8 - data_len));
          byte_valid   <= 1'b1;
          parity_even  <= ~par_reg;
          char_cnt_reg <= (char_cnt_reg == window - 4'd1) ? 4'd0 : char_cnt_reg + 4'd1;
          if (char_cnt_reg == window - 4'd1)
          begin
            miss_used_reg <= 1'b0;
          end
          if (rx_bit)
          begin
            state_reg <= CH_IDLE;
          end
          else if (usart_mode != `MRX_USART_SS_PLAIN && !miss_used_reg)
          begin
            miss_used_reg <= 1'b1;
            state_reg     <= CH_DATA;
            bit_cnt_reg   <= 4'd0;
            par_reg       <= 1'b0;
          end
          else
          begin
            framing_err <= 1'b1;
            state_reg   <= CH_IDLE;
          end
        end
        default:
        begin
          state_reg <= CH_IDLE;
        end
      endcase
    end
  end

endmodule : mrx_rx_char

// ==== rtl/mrx_top.sv ====
// Receive mode, transmit and receive data, and status registers of the line modem.
// Assumes a host on the serial control bus and modem detectors on ref_clk.
`include "mrx_regs.svh"

module mrx_top
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        bus_clk,
  input  wire logic        bus_sel_n,
  input  wire logic        bus_cmd_data,
  output logic             bus_reply_data,
  input  wire logic        gc_reset,
  input  wire logic        interrupt_pin_enable,
  input  wire logic [5:0]  gc_irq_mask,
  input  wire logic        ring_detect,
  input  wire logic        programming_done_flag,
  input  wire logic        tx_ready_flag,
  input  wire logic        tx_underflow_flag,
  input  wire logic [3:0]  modem_det,
  input  wire logic [2:0]  rx_quality,
  input  wire logic [3:0]  tone_det,
  input  wire logic [3:0]  dtmf_code,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  output logic [3:0]       rx_mode_select,
  output logic [2:0]       rx_gain_code,
  output logic             auto_equaliser_enable,
  output logic [1:0]       descrambler_control,
  output logic [2:0]       tone_detector_select,
  output logic [7:0]       tx_byte_out,
  output logic             tx_byte_load,
  output logic             tx_byte_overspeed,
  output logic             host_interrupt_out_n
);
  import mrx_pkg::*;

  logic [2:0]  clk_sync_reg;
  logic [1:0]  sel_sync_reg;
  logic [1:0]  cmd_sync_reg;
  logic        clk_rise;
  logic        clk_fall;
  mrx_ser_e    ser_reg;
  logic [4:0]  bit_cnt_reg;
  logic [4:0]  wr_len_reg;
  logic [7:0]  addr_reg;
  logic [15:0] shift_in_reg;
  logic [15:0] reply_reg;
  logic [7:0]  addr_next;
  logic [15:0] data_next;
  logic        gen_reset_reg;
  logic        soft_clr;
  logic        rd_rx_byte;
  logic        rd_status;
  logic        wr_commit;
  logic [15:0] receive_mode_config_reg;
  logic [7:0]  receive_byte_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [14:5] status_prev_reg;
  logic [14:5] irq_mask_map;
  logic        modem_mode;
  logic        tones_mode;
  logic        ch_valid;
  logic [7:0]  ch_byte;
  logic        ch_framing;
  logic        ch_parity;

  // ----------------------------------------------------------------
  // Bus input synchronisers
  // ----------------------------------------------------------------
  // The bus clock is only sampled, so it must stay below a quarter of ref_clk.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      clk_sync_reg <= 3'b000;
      sel_sync_reg <= 2'b11;
      cmd_sync_reg <= 2'b00;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], bus_clk};
      sel_sync_reg <= {sel_sync_reg[0], bus_sel_n};
      cmd_sync_reg <= {cmd_sync_reg[0], bus_cmd_data};
    end
  end

  assign clk_rise  = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign clk_fall  = ~clk_sync_reg[1] & clk_sync_reg[2];
  assign addr_next = {shift_in_reg[6:0], cmd_sync_reg[1]};
  assign data_next = {shift_in_reg[14:0], cmd_sync_reg[1]};
  assign soft_clr  = gen_reset_reg | gc_reset;

  // ----------------------------------------------------------------
  // Serial bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    gen_reset_reg <= 1'b0;
    rd_rx_byte    <= 1'b0;
    rd_status     <= 1'b0;
    wr_commit     <= 1'b0;
    if (sys_rst || sel_sync_reg[1])
    begin
      ser_reg        <= SER_ADDR;
      bit_cnt_reg    <= 5'd0;
      wr_len_reg     <= `MRX_LEN_BYTE;
      addr_reg       <= 8'h00;
      shift_in_reg   <= 16'h0000;
      reply_reg      <= 16'h0000;
      bus_reply_data <= 1'b0;
    end
    else
    begin
      case (ser_reg)
        SER_ADDR:
        begin
          if (clk_rise)
          begin
            shift_in_reg <= data_next;
            bit_cnt_reg  <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == `MRX_LEN_ADDR - 5'd1)
            begin
              addr_reg    <= addr_next;
              bit_cnt_reg <= 5'd0;
              ser_reg     <= SER_IGNORE;
              case (addr_next)
                `MRX_ADDR_GEN_RESET:
                begin
                  gen_reset_reg <= 1'b1;
                end
                `MRX_ADDR_RX_MODE:
                begin
                  ser_reg    <= SER_WRITE;
                  wr_len_reg <= `MRX_LEN_WORD;
                end
                `MRX_ADDR_TX_BYTE, `MRX_ADDR_TX_BYTE_OVSP:
                begin
                  ser_reg    <= SER_WRITE;
                  wr_len_reg <= `MRX_LEN_BYTE;
                end
                `MRX_ADDR_RX_BYTE:
                begin
                  ser_reg        <= SER_READ;
                  rd_rx_byte     <= 1'b1;
                  reply_reg      <= {receive_byte_reg, 8'h00};
                  bus_reply_data <= receive_byte_reg[7];
                end
                `MRX_ADDR_EVENT_FLAGS:
                begin
                  ser_reg        <= SER_READ;
                  rd_status      <= 1'b1;
                  reply_reg      <= status_reg;
                  bus_reply_data <= status_reg[15];
                end
                default:
                begin
                  ser_reg <= SER_IGNORE;
                end
              endcase
            end
          end
        end
        SER_WRITE:
        begin
          if (clk_rise)
          begin
            shift_in_reg <= data_next;
            bit_cnt_reg  <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == wr_len_reg - 5'd1)
            begin
              wr_commit <= 1'b1;
              ser_reg   <= SER_IGNORE;
            end
          end
        end
        SER_READ:
        begin
          if (clk_fall)
          begin
            reply_reg      <= {reply_reg[14:0], 1'b0};
            bus_reply_data <= reply_reg[14];
          end
        end
        default:
        begin
          ser_reg <= SER_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive mode register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || soft_clr)
    begin
      receive_mode_config_reg <= `MRX_RXM_RESET;
    end
    else if (wr_commit && addr_reg == `MRX_ADDR_RX_MODE)
    begin
      receive_mode_config_reg <= shift_in_reg;
    end
  end

  assign modem_mode = receive_mode_config_reg[`MRX_RXM_MODE_HI:`MRX_RXM_MODE_LO] > `MRX_MODE_TONES;
  assign tones_mode = receive_mode_config_reg[`MRX_RXM_MODE_HI:`MRX_RXM_MODE_LO] == `MRX_MODE_TONES;

  // Front-end controls are re-registered so that every output leaves a flip-flop.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rx_mode_select        <= 4'h0;
      rx_gain_code          <= 3'h0;
      auto_equaliser_enable <= 1'b0;
      descrambler_control   <= 2'h0;
      tone_detector_select  <= 3'h0;
    end
    else
    begin
      rx_mode_select        <= receive_mode_config_reg[`MRX_RXM_MODE_HI:`MRX_RXM_MODE_LO];
      rx_gain_code          <= receive_mode_config_reg[`MRX_RXM_GAIN_HI:`MRX_RXM_GAIN_LO];
      auto_equaliser_enable <= modem_mode & receive_mode_config_reg[`MRX_RXM_EQ_BIT];
      descrambler_control   <= modem_mode ? receive_mode_config_reg[`MRX_RXM_DESC_HI:`MRX_RXM_DESC_LO] : 2'h0;
      tone_detector_select  <= tones_mode ? receive_mode_config_reg[`MRX_RXM_FMT_HI:`MRX_RXM_FMT_LO] : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit byte register
  // ----------------------------------------------------------------
  // The transmit engine shifts tx_byte_out from b0 upward and adds framing itself.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tx_byte_out       <= 8'h00;
      tx_byte_load      <= 1'b0;
      tx_byte_overspeed <= 1'b0;
    end
    else
    begin
      tx_byte_load <= 1'b0;
      if (wr_commit && (addr_reg == `MRX_ADDR_TX_BYTE || addr_reg == `MRX_ADDR_TX_BYTE_OVSP))
      begin
        tx_byte_out       <= shift_in_reg[7:0];
        tx_byte_load      <= 1'b1;
        tx_byte_overspeed <= (addr_reg == `MRX_ADDR_TX_BYTE_OVSP);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive character engine
  // ----------------------------------------------------------------
  mrx_rx_char u_rx_char
  (
    .ref_clk      (ref_clk),
    .clr          (sys_rst | soft_clr),
    .rx_bit_valid (rx_bit_valid),
    .rx_bit       (rx_bit),
    .enable       (modem_mode & receive_mode_config_reg[`MRX_RXM_USART_HI]),
    .usart_mode   (receive_mode_config_reg[`MRX_RXM_USART_HI:`MRX_RXM_USART_LO]),
    .char_format  (receive_mode_config_reg[`MRX_RXM_FMT_HI:`MRX_RXM_FMT_LO]),
    .byte_valid   (ch_valid),
    .byte_data    (ch_byte),
    .framing_err  (ch_framing),
    .parity_even  (ch_parity)
  );

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      receive_byte_reg <= 8'h00;
    end
    else if (ch_valid)
    begin
      receive_byte_reg <= ch_byte;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // Mode-dependent bit meanings
  always_comb
  begin
    status_next      = status_reg & 16'hC000;
    status_next[14]  = ring_detect;
    status_next[13]  = programming_done_flag;
    status_next[12]  = tx_ready_flag;
    status_next[11]  = tx_underflow_flag;
    if (tones_mode)
    begin
      status_next[10]  = tone_det[3];
      status_next[7:5] = tone_det[2:0];
      status_next[3:0] = dtmf_code;
    end
    else if (modem_mode)
    begin
      status_next[10:7] = modem_det;
      status_next[2:0]  = rx_quality;
      status_next[`MRX_ST_RX_READY] = ch_valid | (status_reg[`MRX_ST_RX_READY] & ~rd_rx_byte);
      status_next[`MRX_ST_RX_OVFL]  = (ch_valid & status_reg[`MRX_ST_RX_READY] & ~rd_rx_byte)
                                      | (status_reg[`MRX_ST_RX_OVFL] & ~rd_rx_byte);
      status_next[`MRX_ST_FRAMING]  = ch_framing | (status_reg[`MRX_ST_FRAMING] & ~rd_rx_byte);
      status_next[`MRX_ST_PARITY]   = ch_valid ? ch_parity : status_reg[`MRX_ST_PARITY];
    end
  end

  assign irq_mask_map = {gc_irq_mask[5], gc_irq_mask[4], {2{gc_irq_mask[3]}}, gc_irq_mask[2],
                         {3{gc_irq_mask[1]}}, {2{gc_irq_mask[0]}}};

  // Ring detect keeps working through a control reset, so only sys_rst clears bit 14; a control reset clears bits 13-0, and bit 15 if no masked rise sets it.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      status_reg      <= `MRX_ST_RESET;
      status_prev_reg <= 10'h000;
    end
    else
    begin
      status_prev_reg    <= status_reg[14:5];
      status_reg[14:0]   <= status_next[14:0];
      if (soft_clr)
      begin
        status_reg[13:0] <= 14'h0000;
      end
      if (|(status_reg[14:5] & ~status_prev_reg & irq_mask_map))
      begin
        status_reg[`MRX_ST_IRQ] <= 1'b1;
      end
      else if (rd_status || soft_clr)
      begin
        status_reg[`MRX_ST_IRQ] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      host_interrupt_out_n <= 1'b1;
    end
    else
    begin
      host_interrupt_out_n <= ~(status_reg[`MRX_ST_IRQ] & interrupt_pin_enable);
    end
  end

endmodule : mrx_top

// ==== verif/mrx_host.sv ====
// Host model that drives the serial control bus.
// Assumes ref_clk of 4 ns; each bus clock half lasts 10 ref_clk cycles.
// The device loads the first reply bit on the last address rise and shifts on each fall.
module mrx_host
(
  input  wire logic ref_clk,
  output logic      bus_clk,
  output logic      bus_sel_n,
  output logic      bus_cmd_data,
  input  wire logic bus_reply_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    bus_clk = 1'b0;
    bus_sel_n = 1'b1;
    bus_cmd_data = 1'b0;
  end
  // ----------------------------------------------------------------
  // Transfer
  // ----------------------------------------------------------------
  // Address then data, MSB first; reply sampled just before each fall, from the last address bit on.
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, input int n, output logic [15:0] r);
    logic [23:0] sh;
    sh = {a, d};
    r = 16'h0000;
    @(posedge ref_clk) #1;
    bus_sel_n = 1'b0;
    for (int i = 0; i < 8 + n; i++)
    begin
      bus_cmd_data = sh[23 - i];
      repeat (10) @(posedge ref_clk);
      #1;
      bus_clk = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1;
      if (i >= 7 && i < 7 + n)
        r = {r[14:0], bus_reply_data};
      bus_clk = 1'b0;
    end
    repeat (10) @(posedge ref_clk);
    #1;
    bus_sel_n = 1'b1;
    // The released line shows the inverse, so a stale value never passes.
    bus_cmd_data = ~bus_cmd_data;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : xfer
endmodule : mrx_host

// ==== verif/mrx_top_properties.sv ====
// Port assertions of the receive mode, data and status bank.
// Assumes it is bound to mrx_top.
module mrx_top_properties
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       gc_reset,
  input wire logic       interrupt_pin_enable,
  input wire logic [5:0] gc_irq_mask,
  input wire logic       ring_detect,
  input wire logic [3:0] rx_mode_select,
  input wire logic [2:0] rx_gain_code,
  input wire logic       auto_equaliser_enable,
  input wire logic [1:0] descrambler_control,
  input wire logic [2:0] tone_detector_select,
  input wire logic [7:0] tx_byte_out,
  input wire logic       tx_byte_load,
  input wire logic       tx_byte_overspeed,
  input wire logic       host_interrupt_out_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A masked ring rise with the pin enabled and no reset held.
  sequence ring_armed;
    $rose(ring_detect) && gc_irq_mask[5] ##0 (interrupt_pin_enable && !gc_reset)[*6];
  endsequence
  a_gc_clears_mode:
    assert property (gc_reset[*3] |-> rx_mode_select == 4'h0 && rx_gain_code == 3'h0 && host_interrupt_out_n)
    else $error("control reset left mode or interrupt set");
  a_eq_modem_only:
    assert property (rx_mode_select < 4'h2 |-> !auto_equaliser_enable && descrambler_control == 2'h0)
    else $error("equaliser or descrambler on outside modem modes");
  a_tone_sel_mode:
    assert property (tone_detector_select != 3'h0 |-> rx_mode_select == 4'h1)
    else $error("detector chosen outside tones mode");
  a_pin_needs_enable:
    assert property (!interrupt_pin_enable |=> host_interrupt_out_n)
    else $error("interrupt pin low while disabled");
  a_irq_pin_low:
    assert property (ring_armed |-> !host_interrupt_out_n)
    else $error("masked ring rise gave no interrupt");
  a_tx_byte_held:
    assert property ($changed(tx_byte_out) |-> tx_byte_load || $past(gc_reset))
    else $error("transmit byte changed without a write");
  a_ovsp_on_write:
    assert property ($changed(tx_byte_overspeed) |-> tx_byte_load)
    else $error("overspeed mark changed without a write");
  a_load_one_cycle:
    assert property (tx_byte_load |=> !tx_byte_load)
    else $error("load pulse longer than one cycle");
endmodule : mrx_top_properties

bind mrx_top mrx_top_properties u_props (.ref_clk, .sys_rst, .gc_reset, .interrupt_pin_enable, .gc_irq_mask,
  .ring_detect, .rx_mode_select, .rx_gain_code, .auto_equaliser_enable, .descrambler_control,
  .tone_detector_select, .tx_byte_out, .tx_byte_load, .tx_byte_overspeed, .host_interrupt_out_n);

// ==== verif/testbench.sv ====
// Self-checking bench for the receive mode, data and status bank.
// Assumes the host model speaks the bus and the checker is bound.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, sys_rst, gc_reset, interrupt_pin_enable, ring_detect, programming_done_flag;
  logic        tx_ready_flag, tx_underflow_flag, rx_bit_valid, rx_bit, bus_clk, bus_sel_n, bus_cmd_data;
  logic [5:0]  gc_irq_mask;
  logic [3:0]  modem_det, tone_det, dtmf_code, rx_mode_select;
  logic [2:0]  rx_quality, rx_gain_code, tone_detector_select;
  logic [1:0]  descrambler_control;
  logic [7:0]  tx_byte_out;
  logic        bus_reply_data, auto_equaliser_enable, tx_byte_load, tx_byte_overspeed, host_interrupt_out_n;
  logic [15:0] rd;
  int          err_total, num_checks, loads;
  mrx_top dut (.ref_clk, .sys_rst, .bus_clk, .bus_sel_n, .bus_cmd_data, .bus_reply_data, .gc_reset,
    .interrupt_pin_enable, .gc_irq_mask, .ring_detect, .programming_done_flag, .tx_ready_flag,
    .tx_underflow_flag, .modem_det, .rx_quality, .tone_det, .dtmf_code, .rx_bit_valid, .rx_bit,
    .rx_mode_select, .rx_gain_code, .auto_equaliser_enable, .descrambler_control, .tone_detector_select,
    .tx_byte_out, .tx_byte_load, .tx_byte_overspeed, .host_interrupt_out_n);
  mrx_host host (.ref_clk, .bus_clk, .bus_sel_n, .bus_cmd_data, .bus_reply_data);
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (tx_byte_load === 1'b1)
      loads++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic rx_send(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk) #1;
      rx_bit = b[i];
      rx_bit_valid = 1'b1;
      @(posedge ref_clk) #1;
      rx_bit_valid = 1'b0;
    end
  endtask : rx_send
  // Waits are fixed lengths, so this bound only catches a stuck run.
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
  initial
  begin
    {gc_reset, interrupt_pin_enable, gc_irq_mask, ring_detect, programming_done_flag, tx_ready_flag} = '0;
    {tx_underflow_flag, modem_det, rx_quality, tone_det, dtmf_code, rx_bit_valid, rx_bit} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check({host_interrupt_out_n, rx_mode_select, tx_byte_out}, 16'h1000);
    for (int m = 0; m < 16; m++)
    begin
      host.xfer(8'hE2, (m == 0) ? 16'h0000 : {m[3:0], m[2:0], (m > 9) ? 9'h1C4 : 9'h004}, 16, rd);
      check({rx_mode_select, rx_gain_code, auto_equaliser_enable, descrambler_control, tone_detector_select},
        {m[3:0], (m == 0) ? 3'h0 : m[2:0], m > 9, (m > 9) ? 2'h3 : 2'h0, (m == 1) ? 3'h4 : 3'h0});
    end
    for (int k = 0; k < 4; k++)
    begin
      host.xfer(8'hE2, {7'h0F, 6'h00, k[2:0]}, 16, rd);
      check(tone_detector_select, k[2:0]);
    end
    host.xfer(8'hE2, 16'h0000, 16, rd);
    check(rd, 16'h0000);
    $display("mode tests done");
    {ring_detect, programming_done_flag, tx_ready_flag, gc_reset} = 4'hF;
    host.xfer(8'hE6, 16'h0000, 16, rd);
    check({rd[14:0], rx_mode_select}, 19'h40000);
    gc_reset = 1'b0;
    host.xfer(8'hE6, 16'h0000, 16, rd);
    check(rd[15:11], 5'h0E);
    ring_detect = 1'b0;
    host.xfer(8'hE2, 16'hF000, 16, rd);
    host.xfer(8'h01, 16'h0000, 0, rd);
    check(rx_mode_select, 4'h0);
    {ring_detect, gc_irq_mask, interrupt_pin_enable} = 8'hC1;
    repeat (8) @(posedge ref_clk);
    #1;
    check(host_interrupt_out_n, 1'b0);
    host.xfer(8'hE6, 16'h0000, 16, rd);
    check({rd[15], host_interrupt_out_n}, 2'h3);
    $display("status tests done");
    host.xfer(8'hE3, 16'hA500, 8, rd);
    check({tx_byte_out, tx_byte_overspeed}, 9'h14A);
    host.xfer(8'hE4, 16'h3C00, 8, rd);
    check({tx_byte_out, tx_byte_overspeed, 7'(loads)}, 16'h3C82);
    $display("transmit tests done");
    host.xfer(8'hE2, 16'hFFF8, 16, rd);
    rx_send(16'h00B4, 8);
    host.xfer(8'hE6, 16'h0000, 16, rd);
    check(rd[6], 1'b1);
    host.xfer(8'hE5, 16'h0000, 8, rd);
    check(rd, 16'h00B4);
    host.xfer(8'hE6, 16'h0000, 16, rd);
    check(rd[6], 1'b0);
    host.xfer(8'hE2, 16'hFFF4, 16, rd);
    rx_send(16'h0355, 10);
    host.xfer(8'hE5, 16'h0000, 8, rd);
    check(rd, 16'h0055);
    $display("receive tests done");
    stop_test();
  end
endmodule : testbench
